/* rtcb_pkg.sv */
// ==========================================================
// register map, field positions and reset values
package rtcb_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;

	localparam logic [4:0] OFS_CONTROL_A    = 5'h00;
	localparam logic [4:0] OFS_SYNC_STATUS  = 5'h01;
	localparam logic [4:0] OFS_IRQ_ENABLE   = 5'h02;
	localparam logic [4:0] OFS_IRQ_FLAGS    = 5'h03;
	localparam logic [4:0] OFS_BYTE_LATCH   = 5'h04;
	localparam logic [4:0] OFS_DEBUG_CTRL   = 5'h05;
	localparam logic [4:0] OFS_CLOCK_SELECT = 5'h07;
	localparam logic [4:0] OFS_COUNT_LO     = 5'h08;
	localparam logic [4:0] OFS_COUNT_HI     = 5'h09;
	localparam logic [4:0] OFS_TOP_LO       = 5'h0a;
	localparam logic [4:0] OFS_TOP_HI       = 5'h0b;
	localparam logic [4:0] OFS_COMPARE_LO   = 5'h0c;
	localparam logic [4:0] OFS_COMPARE_HI   = 5'h0d;
	localparam logic [4:0] OFS_PER_CONTROL  = 5'h10;
	localparam logic [4:0] OFS_PER_STATUS   = 5'h11;
	localparam logic [4:0] OFS_PER_IRQ_EN   = 5'h12;
	localparam logic [4:0] OFS_PER_IRQ_FLAG = 5'h13;
	localparam logic [4:0] OFS_PER_DEBUG    = 5'h15;

	// control_a fields
	localparam int BIT_STANDBY_RUN = 7;
	localparam int BIT_DIV_HI      = 6;
	localparam int BIT_DIV_LO      = 3;
	localparam int BIT_ENABLE      = 0;
	localparam logic [7:0] CONTROL_A_MASK = 8'hf9;

	// sync slot indices; slots 0 to 3 are also the sync_status bits
	localparam int SYNC_CONTROL = 0;
	localparam int SYNC_COUNT   = 1;
	localparam int SYNC_TOP     = 2;
	localparam int SYNC_COMPARE = 3;
	localparam int SYNC_PERIODIC = 4;
	localparam int SYNC_SLOTS   = 5;

	// irq bits
	localparam int BIT_WRAP    = 0;
	localparam int BIT_COMPARE = 1;
	localparam int BIT_PERIODIC = 0;
	localparam int BIT_RUN_HALTED = 0;

	// periodic_control fields
	localparam int BIT_PER_HI = 6;
	localparam int BIT_PER_LO = 3;
	localparam int BIT_PER_EN = 0;
	localparam logic [7:0] PER_CONTROL_MASK = 8'h79;
	localparam logic [3:0] PER_CODE_OFF  = 4'h0;
	localparam logic [3:0] PER_CODE_RSVD = 4'hf;

	// tick source codes
	localparam logic [1:0] SRC_INT_FAST = 2'h0;
	localparam logic [1:0] SRC_INT_SLOW = 2'h1;
	localparam logic [1:0] SRC_RESERVED = 2'h2;
	localparam logic [1:0] SRC_EXT_PIN  = 2'h3;

	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [15:0] RST_TOP     = 16'hffff;
	localparam logic [15:0] RST_COMPARE = 16'h0000;
	localparam logic [1:0]  RST_SRC     = 2'h0;

	// slow ticks between a write and its effect
	localparam logic [1:0] SYNC_TICKS = 2'h2;
	localparam int PRESC_W = 15;
endpackage

/* rtcb_regbank.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - standby bit keeps counter running in standby
// - divider field divides tick by two-power
// - divider change lands after two ticks
// - enable bit starts and stops counter
// - status shows compare and top pending
// - status shows count and control pending
// - compare enable gates compare interrupt
// - wrap enable gates wrap interrupt
// - compare match sets compare flag
// - wrap to zero sets wrap flag
// - write one clears flag, zero keeps
// - readable writable byte latch for 16-bit
// - one latch shared by all wide registers
// - interrupt held while flag and enable set
// - run bit keeps counting while cpu halted
// - two-bit select picks slow tick source
module rtcb_regbank #(
	parameter int CNT_W = 16
) (
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire logic [rtcb_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [rtcb_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                      reg_write,
	input  wire logic                      reg_read,
	output logic      [rtcb_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                      tick_fast_pin,
	input  wire logic                      tick_slow_pin,
	input  wire logic                      tick_ext_pin,
	input  wire logic                      standby_sleep,
	input  wire logic                      cpu_halted,
	output logic                           irq
);

	// ==========================================================
	// register address decode
	// the three high-byte offsets share one decode term: they
	// all land in the byte latch, never in the wide register
	// itself, so a lone high write shows only in the latch until
	// its low byte follows
	// unmapped offsets match no term and so ignore writes
	wire logic wr_ctrl    = reg_write && reg_addr == rtcb_pkg::OFS_CONTROL_A;
	wire logic wr_ien     = reg_write && reg_addr == rtcb_pkg::OFS_IRQ_ENABLE;
	wire logic wr_iflg    = reg_write && reg_addr == rtcb_pkg::OFS_IRQ_FLAGS;
	wire logic wr_latch   = reg_write && reg_addr == rtcb_pkg::OFS_BYTE_LATCH;
	wire logic wr_dbg     = reg_write && reg_addr == rtcb_pkg::OFS_DEBUG_CTRL;
	wire logic wr_src     = reg_write && reg_addr == rtcb_pkg::OFS_CLOCK_SELECT;
	wire logic wr_cnt_lo  = reg_write && reg_addr == rtcb_pkg::OFS_COUNT_LO;
	wire logic wr_top_lo  = reg_write && reg_addr == rtcb_pkg::OFS_TOP_LO;
	wire logic wr_cmp_lo  = reg_write && reg_addr == rtcb_pkg::OFS_COMPARE_LO;
	wire logic wr_hi      = reg_write &&
		(reg_addr == rtcb_pkg::OFS_COUNT_HI ||
		 reg_addr == rtcb_pkg::OFS_TOP_HI ||
		 reg_addr == rtcb_pkg::OFS_COMPARE_HI);
	wire logic wr_pctl    = reg_write && reg_addr == rtcb_pkg::OFS_PER_CONTROL;
	wire logic wr_pien    = reg_write && reg_addr == rtcb_pkg::OFS_PER_IRQ_EN;
	wire logic wr_pflg    = reg_write && reg_addr == rtcb_pkg::OFS_PER_IRQ_FLAG;
	wire logic wr_pdbg    = reg_write && reg_addr == rtcb_pkg::OFS_PER_DEBUG;
	wire logic rd_cnt_lo  = reg_read && reg_addr == rtcb_pkg::OFS_COUNT_LO;
	wire logic rd_top_lo  = reg_read && reg_addr == rtcb_pkg::OFS_TOP_LO;
	wire logic rd_cmp_lo  = reg_read && reg_addr == rtcb_pkg::OFS_COMPARE_LO;

	// ==========================================================
	// software-visible storage
	// only the documented bits are kept; narrow fields are
	// stored at their own width so unused bits cannot hold state
	// wide registers keep the software copy apart from the value
	// in effect, which only changes once its sync slot drains
	logic [7:0]       control_a_r;
	logic [1:0]       irq_enable_r;
	logic [1:0]       irq_flags_r;
	logic [7:0]       byte_latch_r;
	logic             run_while_halted_r;
	logic [1:0]       tick_source_select_r;
	logic [7:0]       periodic_control_r;
	logic             periodic_irq_en_r;
	logic             periodic_irq_flag_r;
	logic             periodic_run_halted_r;
	logic [CNT_W-1:0] count_wr_r;
	logic [CNT_W-1:0] top_wr_r;
	logic [CNT_W-1:0] compare_wr_r;

	// values in effect on the counting side
	logic [7:0]       control_eff_r;
	logic [7:0]       periodic_eff_r;
	logic [CNT_W-1:0] counter_value_r;
	logic [CNT_W-1:0] top_eff_r;
	logic [CNT_W-1:0] compare_eff_r;
	logic [rtcb_pkg::PRESC_W-1:0] presc_r;

	// ==========================================================
	// tick source sampling: three stages, change taken when
	// the second and third stages agree
	// the agreed level starts low like an idle pin, so no false
	// edge follows reset; a pin must stay at each level for at
	// least two clocks or its edges are lost
	logic [2:0] src_pin;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic [2:0] lvl_r;
	logic [2:0] rise;
	assign src_pin = {tick_ext_pin, tick_slow_pin, tick_fast_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					s1_r[gi]  <= 1'b0;
					s2_r[gi]  <= 1'b0;
					s3_r[gi]  <= 1'b0;
					lvl_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= src_pin[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi])
						lvl_r[gi] <= s3_r[gi];
				end
			end
			assign rise[gi] = s2_r[gi] && s3_r[gi] && !lvl_r[gi];
		end
	endgenerate

	// reserved code gives no tick at all
	wire logic tick =
		(tick_source_select_r == rtcb_pkg::SRC_INT_FAST) ? rise[0] :
		(tick_source_select_r == rtcb_pkg::SRC_INT_SLOW) ? rise[1] :
		(tick_source_select_r == rtcb_pkg::SRC_EXT_PIN)  ? rise[2] :
		1'b0;

	// ==========================================================
	// write synchronisation: a write parks in a slot, the slot
	// shows pending, and the value lands after two ticks
	// the wait counts ticks of the selected source only, so with
	// the reserved source code a pending write never drains;
	// software must pick a live source before it writes
	logic [rtcb_pkg::SYNC_SLOTS-1:0] sync_start;
	logic [rtcb_pkg::SYNC_SLOTS-1:0] sync_pend_r;
	logic [rtcb_pkg::SYNC_SLOTS-1:0] sync_apply;
	logic [1:0] sync_cnt_r [rtcb_pkg::SYNC_SLOTS];
	assign sync_start[rtcb_pkg::SYNC_CONTROL]  = wr_ctrl;
	assign sync_start[rtcb_pkg::SYNC_COUNT]    = wr_cnt_lo;
	assign sync_start[rtcb_pkg::SYNC_TOP]      = wr_top_lo;
	assign sync_start[rtcb_pkg::SYNC_COMPARE]  = wr_cmp_lo;
	assign sync_start[rtcb_pkg::SYNC_PERIODIC] = wr_pctl;

	generate
		for (gi = 0; gi < rtcb_pkg::SYNC_SLOTS; gi++) begin : g_sync
			// a fresh write restarts the wait so the newest value wins
			assign sync_apply[gi] = sync_pend_r[gi] && !sync_start[gi] &&
				tick && sync_cnt_r[gi] == rtcb_pkg::SYNC_TICKS - 2'h1;
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					sync_pend_r[gi] <= 1'b0;
					sync_cnt_r[gi]  <= 2'h0;
				end else if (sync_start[gi]) begin
					sync_pend_r[gi] <= 1'b1;
					sync_cnt_r[gi]  <= 2'h0;
				end else if (sync_apply[gi]) begin
					sync_pend_r[gi] <= 1'b0;
					sync_cnt_r[gi]  <= 2'h0;
				end else if (sync_pend_r[gi] && tick) begin
					sync_cnt_r[gi] <= sync_cnt_r[gi] + 2'h1;
				end
			end
		end
	endgenerate

	// ==========================================================
	// counting side
	// one shared prescaler feeds both the counter and the
	// periodic timer, so the first periodic event after enable
	// depends on where the prescaler stands at that moment
	// standby and halt gating act on the value in effect, not
	// on a control write that is still pending
	wire logic [3:0] div_code =
		control_eff_r[rtcb_pkg::BIT_DIV_HI:rtcb_pkg::BIT_DIV_LO];
	wire logic [3:0] per_code =
		periodic_eff_r[rtcb_pkg::BIT_PER_HI:rtcb_pkg::BIT_PER_LO];
	wire logic cnt_enable = control_eff_r[rtcb_pkg::BIT_ENABLE];
	wire logic pit_enable = periodic_eff_r[rtcb_pkg::BIT_PER_EN];
	wire logic cnt_allowed = cnt_enable &&
		!(standby_sleep && !control_eff_r[rtcb_pkg::BIT_STANDBY_RUN]) &&
		!(cpu_halted && !run_while_halted_r);
	wire logic pit_allowed = pit_enable &&
		!(cpu_halted && !periodic_run_halted_r);
	// prescaler is held at zero only when both users are off
	wire logic presc_run = tick && (cnt_allowed || pit_allowed);

	wire logic [rtcb_pkg::PRESC_W-1:0] div_mask =
		rtcb_pkg::PRESC_W'((32'h1 << div_code) - 32'h1);
	wire logic [rtcb_pkg::PRESC_W-1:0] pit_mask =
		rtcb_pkg::PRESC_W'((32'h1 << (per_code + 4'h1)) - 32'h1);
	// step when the low div_code bits are all ones
	wire logic cnt_step = presc_run && cnt_allowed &&
		(presc_r & div_mask) == div_mask;
	wire logic pit_event = presc_run && pit_allowed &&
		per_code != rtcb_pkg::PER_CODE_OFF &&
		per_code != rtcb_pkg::PER_CODE_RSVD &&
		(presc_r & pit_mask) == pit_mask;
	wire logic at_top = counter_value_r == top_eff_r;
	wire logic wrap_overflow = cnt_step && at_top;
	wire logic compare_match = cnt_step &&
		(at_top ? '0 : counter_value_r + 1'b1) == compare_eff_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			presc_r <= '0;
		else if (!(cnt_allowed || pit_allowed))
			presc_r <= '0;
		else if (presc_run)
			presc_r <= presc_r + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			counter_value_r <= rtcb_pkg::RST_COUNT;
		else if (sync_apply[rtcb_pkg::SYNC_COUNT])
			counter_value_r <= count_wr_r;
		else if (wrap_overflow)
			counter_value_r <= '0;
		else if (cnt_step)
			counter_value_r <= counter_value_r + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			control_eff_r  <= rtcb_pkg::RST_BYTE;
			periodic_eff_r <= rtcb_pkg::RST_BYTE;
			top_eff_r      <= rtcb_pkg::RST_TOP;
			compare_eff_r  <= rtcb_pkg::RST_COMPARE;
		end else begin
			if (sync_apply[rtcb_pkg::SYNC_CONTROL])
				control_eff_r <= control_a_r;
			if (sync_apply[rtcb_pkg::SYNC_PERIODIC])
				periodic_eff_r <= periodic_control_r;
			if (sync_apply[rtcb_pkg::SYNC_TOP])
				top_eff_r <= top_wr_r;
			if (sync_apply[rtcb_pkg::SYNC_COMPARE])
				compare_eff_r <= compare_wr_r;
		end
	end

	// ==========================================================
	// software registers and the shared byte latch
	// control and periodic writes are masked here so readback
	// shows only the implemented bits
	// wide registers commit on the low-byte write: the high
	// half comes from the latch filled by the earlier high write
	wire logic [CNT_W-1:0] commit_val = {byte_latch_r, reg_wdata};

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			control_a_r          <= rtcb_pkg::RST_BYTE;
			irq_enable_r         <= 2'h0;
			run_while_halted_r   <= 1'b0;
			tick_source_select_r <= rtcb_pkg::RST_SRC;
			periodic_control_r   <= rtcb_pkg::RST_BYTE;
			periodic_irq_en_r    <= 1'b0;
			periodic_run_halted_r <= 1'b0;
			count_wr_r           <= rtcb_pkg::RST_COUNT;
			top_wr_r             <= rtcb_pkg::RST_TOP;
			compare_wr_r         <= rtcb_pkg::RST_COMPARE;
		end else begin
			// software waits for control pending clear first
			if (wr_ctrl)
				control_a_r <= reg_wdata & rtcb_pkg::CONTROL_A_MASK;
			if (wr_ien)
				irq_enable_r <= reg_wdata[1:0];
			if (wr_dbg)
				run_while_halted_r <= reg_wdata[rtcb_pkg::BIT_RUN_HALTED];
			if (wr_src)
				tick_source_select_r <= reg_wdata[1:0];
			if (wr_pctl)
				periodic_control_r <=
					reg_wdata & rtcb_pkg::PER_CONTROL_MASK;
			if (wr_pien)
				periodic_irq_en_r <= reg_wdata[rtcb_pkg::BIT_PERIODIC];
			if (wr_pdbg)
				periodic_run_halted_r <= reg_wdata[rtcb_pkg::BIT_RUN_HALTED];
			// low byte write commits both halves together
			if (wr_cnt_lo)
				count_wr_r <= commit_val;
			if (wr_top_lo)
				top_wr_r <= commit_val;
			if (wr_cmp_lo)
				compare_wr_r <= commit_val;
		end
	end

	// one latch serves every wide register, so interleaved
	// wide accesses from two contexts corrupt each other
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			byte_latch_r <= rtcb_pkg::RST_BYTE;
		else if (wr_latch || wr_hi)
			byte_latch_r <= reg_wdata;
		else if (rd_cnt_lo)
			byte_latch_r <= counter_value_r[15:8];
		else if (rd_top_lo)
			byte_latch_r <= top_wr_r[15:8];
		else if (rd_cmp_lo)
			byte_latch_r <= compare_wr_r[15:8];
	end

	// ==========================================================
	// sticky flags: a set in the clearing cycle wins
	// losing an event is worse than one spurious interrupt, so
	// a clear that meets a new event leaves the flag set
	// flags set whatever the enables say; the enables only gate
	// the interrupt output
	wire logic [1:0] evt = {compare_match, wrap_overflow};
	wire logic [1:0] clr = wr_iflg ? reg_wdata[1:0] : 2'h0;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_flags_r         <= 2'h0;
			periodic_irq_flag_r <= 1'b0;
		end else begin
			irq_flags_r <= (irq_flags_r & ~clr) | evt;
			periodic_irq_flag_r <= (periodic_irq_flag_r &
				~(wr_pflg && reg_wdata[rtcb_pkg::BIT_PERIODIC])) | pit_event;
		end
	end

	// held as long as an enabled flag stays set
	assign irq = |(irq_flags_r & irq_enable_r) ||
		(periodic_irq_flag_r && periodic_irq_en_r);

	// ==========================================================
	// read path, data one cycle after the strobe
	// read data return to zero outside the answer slot, so a
	// stale value is never mistaken for a fresh read
	// a low-byte read of a wide register also loads the latch,
	// which is why the high half must be read second
	wire logic [7:0] status_val = {4'h0,
		sync_pend_r[rtcb_pkg::SYNC_COMPARE],
		sync_pend_r[rtcb_pkg::SYNC_TOP],
		sync_pend_r[rtcb_pkg::SYNC_COUNT],
		sync_pend_r[rtcb_pkg::SYNC_CONTROL]};
	wire logic [7:0] rd_mux =
		(reg_addr == rtcb_pkg::OFS_CONTROL_A) ? control_a_r :
		(reg_addr == rtcb_pkg::OFS_SYNC_STATUS) ? status_val :
		(reg_addr == rtcb_pkg::OFS_IRQ_ENABLE) ? {6'h0, irq_enable_r} :
		(reg_addr == rtcb_pkg::OFS_IRQ_FLAGS) ? {6'h0, irq_flags_r} :
		(reg_addr == rtcb_pkg::OFS_BYTE_LATCH) ? byte_latch_r :
		(reg_addr == rtcb_pkg::OFS_DEBUG_CTRL) ?
			{7'h0, run_while_halted_r} :
		(reg_addr == rtcb_pkg::OFS_CLOCK_SELECT) ?
			{6'h0, tick_source_select_r} :
		(reg_addr == rtcb_pkg::OFS_COUNT_LO) ? counter_value_r[7:0] :
		(reg_addr == rtcb_pkg::OFS_TOP_LO) ? top_wr_r[7:0] :
		(reg_addr == rtcb_pkg::OFS_COMPARE_LO) ? compare_wr_r[7:0] :
		(reg_addr == rtcb_pkg::OFS_COUNT_HI ||
		 reg_addr == rtcb_pkg::OFS_TOP_HI ||
		 reg_addr == rtcb_pkg::OFS_COMPARE_HI) ? byte_latch_r :
		(reg_addr == rtcb_pkg::OFS_PER_CONTROL) ? periodic_control_r :
		(reg_addr == rtcb_pkg::OFS_PER_STATUS) ?
			{7'h0, sync_pend_r[rtcb_pkg::SYNC_PERIODIC]} :
		(reg_addr == rtcb_pkg::OFS_PER_IRQ_EN) ?
			{7'h0, periodic_irq_en_r} :
		(reg_addr == rtcb_pkg::OFS_PER_IRQ_FLAG) ?
			{7'h0, periodic_irq_flag_r} :
		(reg_addr == rtcb_pkg::OFS_PER_DEBUG) ?
			{7'h0, periodic_run_halted_r} :
		8'h00;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_read ? rd_mux : 8'h00;
	end

endmodule

/* rtcb_regbank_asserts.sv */
`timescale 1ns/100ps
// ============================================================
// bus-side checker, sees only the top ports
module rtcb_regbank_chk (
	input wire logic       sys_clk,
	input wire logic       resetn,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq
);
	logic [2:0] en_r;
	logic       rsv_rd;

	assign rsv_rd = reg_read && (reg_addr > 5'h15 ||
		reg_addr inside {5'h06, 5'h0e, 5'h0f, 5'h14});

	// shadow of all three interrupt enable bits, fed by bus writes only
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			en_r <= 3'h0;
		end else if (reg_write && reg_addr == 5'h02) begin
			en_r[1:0] <= reg_wdata[1:0];
		end else if (reg_write && reg_addr == 5'h12) begin
			en_r[2] <= reg_wdata[0];
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ============================================================
	// properties
	a_rdata_slot: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
		else $error("read data outside its slot");
	a_reserved_zero: assert property ($past(rsv_rd) |-> reg_rdata == 8'h00)
		else $error("reserved offset read nonzero");
	a_status_unused: assert property ($past(reg_read) &&
		$past(reg_addr) == 5'h01 |-> reg_rdata[7:4] == 4'h0)
		else $error("unused status bits set");
	a_ctrl_pending: assert property (reg_write && reg_addr == 5'h00 ##1
		reg_read && reg_addr == 5'h01 |=> reg_rdata[0])
		else $error("control pending not shown");
	a_top_pending: assert property (reg_write && reg_addr == 5'h0a ##1
		reg_read && reg_addr == 5'h01 |=> reg_rdata[2])
		else $error("top pending not shown");
	a_latch_back: assert property (reg_write && reg_addr == 5'h04 ##1
		reg_read && reg_addr == 5'h04 |=> reg_rdata == $past(reg_wdata, 2))
		else $error("byte latch readback wrong");
	a_latch_alias: assert property (reg_write && reg_addr == 5'h0b ##1
		reg_read && reg_addr == 5'h04 |=> reg_rdata == $past(reg_wdata, 2))
		else $error("high byte write missed the latch");
	a_ctrl_back: assert property (reg_write && reg_addr == 5'h00 ##1
		reg_read && reg_addr == 5'h00 |=>
		reg_rdata == ($past(reg_wdata, 2) & 8'hf9))
		else $error("control readback wrong");
	a_irq_masked: assert property (en_r == 3'h0 |-> !irq)
		else $error("interrupt with all enables clear");
	a_irq_holds: assert property (irq && !(reg_write &&
		reg_addr inside {5'h02, 5'h03, 5'h12, 5'h13}) |=> irq)
		else $error("interrupt dropped without a clear");
endmodule

bind rtcb_regbank rtcb_regbank_chk u_chk (
	.sys_clk  (sys_clk),
	.resetn   (resetn),
	.reg_addr (reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read (reg_read),
	.reg_rdata(reg_rdata),
	.irq      (irq)
);

/* rtcb_regbank_tb.sv */
`timescale 1ns/100ps
// ============================================================
// self-checking bench for the register bank
module rtcb_regbank_tb;
	logic       sys_clk = 1'b0;
	logic       resetn;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_write;
	logic       reg_read;
	logic [7:0] reg_rdata;
	logic [2:0] pin_r = 3'h0;
	logic [2:0] pin_en;
	logic [2:0] tk_cnt = 3'h0;
	logic       standby_sleep;
	logic       cpu_halted;
	logic       irq;
	int         err_total;
	int         total_checks;
	logic [7:0] d;
	logic [7:0] c0;

	rtcb_regbank dut (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_write    (reg_write),
		.reg_read     (reg_read),
		.reg_rdata    (reg_rdata),
		.tick_fast_pin(pin_r[0]),
		.tick_slow_pin(pin_r[1]),
		.tick_ext_pin (pin_r[2]),
		.standby_sleep(standby_sleep),
		.cpu_halted   (cpu_halted),
		.irq          (irq)
	);

	always #20 sys_clk = ~sys_clk;

	// ticks rise every 8 clocks: long enough for the input sampler
	always @(posedge sys_clk) begin
		tk_cnt <= tk_cnt + 3'h1;
		pin_r  <= {3{tk_cnt[2]}} & pin_en;
	end

	// ============================================================
	// bus and compare tasks
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// the write strobe is held so writes may run back to back
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		reg_write <= 1'b1;
		reg_read  <= 1'b0;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		reg_write <= 1'b0;
		reg_read  <= 1'b1;
		reg_addr  <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		reg_write <= 1'b0;
		reg_read  <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		rd(a, d);
		chk8(d, e);
	endtask
	task automatic irq_is(input logic e);
		idle(0);
		@(negedge sys_clk);
		chk1(irq, e);
		@(posedge sys_clk);
	endtask
	task automatic settle();
		int i;
		for (i = 0; i < 60; i++) begin
			rd(5'h01, d);
			if (d === 8'h00) break;
		end
		chk8(d, 8'h00);
	endtask

	// ============================================================
	// scenarios
	task automatic t_reset();
		int a;
		for (a = 0; a < 32; a++) begin
			rchk(a[4:0], (a == 10 || a == 11) ? 8'hff : 8'h00);
		end
		$display("reset values done");
	endtask
	task automatic t_mask();
		int i;
		logic [4:0] ma[9];
		logic [7:0] me[9];
		ma = '{5'h02, 5'h05, 5'h07, 5'h06, 5'h0e, 5'h14, 5'h1f, 5'h04, 5'h12};
		me = '{8'h03, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h01};
		for (i = 0; i < 9; i++) begin
			wr(ma[i], 8'hff);
			rchk(ma[i], me[i]);
			wr(ma[i], 8'h00);
		end
		idle(1);
		$display("unused bits done");
	endtask
	task automatic t_sync();
		int i;
		logic [4:0] sa[4];
		sa = '{5'h00, 5'h08, 5'h0a, 5'h0c};
		for (i = 0; i < 4; i++) begin
			wr(5'h04, 8'hff);
			wr(sa[i], i == 0 ? 8'h00 : 8'hff);
			rchk(5'h01, 8'h01 << i[2:0]);
			settle();
		end
		$display("sync flags done");
	endtask
	task automatic t_flags();
		wr(5'h0b, 8'h00);
		wr(5'h0a, 8'h03);
		settle();
		wr(5'h0d, 8'h00);
		wr(5'h0c, 8'h02);
		settle();
		wr(5'h09, 8'h00);
		wr(5'h08, 8'h00);
		settle();
		wr(5'h02, 8'h03);
		wr(5'h00, 8'h01);
		settle();
		idle(200);
		rchk(5'h03, 8'h03);
		irq_is(1'b1);
		wr(5'h00, 8'h00);
		settle();
		wr(5'h02, 8'h01);
		irq_is(1'b1);
		wr(5'h03, 8'h01);
		irq_is(1'b0);
		rchk(5'h03, 8'h02);
		wr(5'h02, 8'h02);
		irq_is(1'b1);
		wr(5'h03, 8'h02);
		irq_is(1'b0);
		rchk(5'h03, 8'h00);
		wr(5'h02, 8'h00);
		$display("interrupt flags done");
	endtask
	task automatic t_latch();
		wr(5'h09, 8'h12);
		wr(5'h08, 8'h34);
		settle();
		rchk(5'h08, 8'h34);
		rchk(5'h04, 8'h12);
		rchk(5'h09, 8'h12);
		wr(5'h0b, 8'h56);
		rchk(5'h04, 8'h56);
		wr(5'h0a, 8'h78);
		rchk(5'h0a, 8'h78);
		rchk(5'h0b, 8'h56);
		wr(5'h0b, 8'hff);
		wr(5'h0a, 8'hff);
		settle();
		$display("byte latch done");
	endtask
	// mv: whether the counter low byte is expected to advance
	task automatic hold(input logic [7:0] ct, input logic dbg, hlt, sby,
		input logic [1:0] sel, input logic [2:0] pe, input logic mv);
		pin_en <= 3'h7;
		wr(5'h07, 8'h00);
		rchk(5'h01, 8'h00);
		wr(5'h00, ct);
		rchk(5'h00, ct & 8'hf9);
		settle();
		wr(5'h05, {7'h00, dbg});
		wr(5'h07, {6'h00, sel});
		standby_sleep <= sby;
		cpu_halted    <= hlt;
		pin_en        <= pe;
		idle(30);
		rd(5'h08, c0);
		idle(200);
		rd(5'h08, d);
		chk1(d != c0, mv);
		standby_sleep <= 1'b0;
		cpu_halted    <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		err_total++;
		print_verdict();
	end

	initial begin
		resetn        = 1'b0;
		reg_addr      = 5'h00;
		reg_wdata     = 8'h00;
		reg_write     = 1'b0;
		reg_read      = 1'b0;
		standby_sleep = 1'b0;
		cpu_halted    = 1'b0;
		pin_en        = 3'h7;
		err_total     = 0;
		total_checks  = 0;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset();
		t_mask();
		t_sync();
		t_flags();
		t_latch();
		hold(8'h01, 1'b0, 1'b0, 1'b0, 2'h0, 3'h1, 1'b1);
		hold(8'h01, 1'b0, 1'b0, 1'b1, 2'h0, 3'h1, 1'b0);
		hold(8'h81, 1'b0, 1'b0, 1'b1, 2'h0, 3'h1, 1'b1);
		hold(8'h01, 1'b0, 1'b1, 1'b0, 2'h0, 3'h1, 1'b0);
		hold(8'h01, 1'b1, 1'b1, 1'b0, 2'h0, 3'h1, 1'b1);
		hold(8'h00, 1'b0, 1'b0, 1'b0, 2'h0, 3'h1, 1'b0);
		hold(8'h79, 1'b0, 1'b0, 1'b0, 2'h0, 3'h7, 1'b0);
		hold(8'h09, 1'b0, 1'b0, 1'b0, 2'h0, 3'h1, 1'b1);
		hold(8'h01, 1'b0, 1'b0, 1'b0, 2'h1, 3'h5, 1'b0);
		hold(8'h01, 1'b0, 1'b0, 1'b0, 2'h1, 3'h2, 1'b1);
		hold(8'h01, 1'b0, 1'b0, 1'b0, 2'h3, 3'h4, 1'b1);
		hold(8'h01, 1'b0, 1'b0, 1'b0, 2'h2, 3'h7, 1'b0);
		hold(8'h01, 1'b0, 1'b0, 1'b0, 2'h0, 3'h6, 1'b0);
		$display("run control done");
		idle(2);
		print_verdict();
	end
endmodule
